// File: rtl/dhl_defs.svh
`ifndef DHL_DEFS_SVH
`define DHL_DEFS_SVH

// Register byte offsets on the bus
`define DHL_REG_CTRL 8'h00
`define DHL_REG_BAUD 8'h04
`define DHL_REG_STATUS 8'h08
`define DHL_REG_TXREQ 8'h0C
`define DHL_REG_STORE 8'h10
`define DHL_REG_PKTSTAT 8'h14

// Control register field positions
`define DHL_CTRL_SER 0
`define DHL_CTRL_RISE 1
`define DHL_CTRL_QEN 2
`define DHL_CTRL_PKT 3
`define DHL_CTRL_PAR_LO 4

// Control reset values and parity codes
`define DHL_CTRL_SER_RST 1'b0
`define DHL_CTRL_RISE_RST 1'b1
`define DHL_PAR_NONE 2'h0
`define DHL_PAR_EVEN 2'h1
`define DHL_PAR_ODD 2'h2

// Transmit request kinds
`define DHL_KIND_RAW 2'h0
`define DHL_KIND_PORT 2'h1
`define DHL_KIND_CHK 2'h2

// Framing and command bytes
`define DHL_HDR 8'h02
`define DHL_FTR 8'h03
`define DHL_ACK_OK 8'h50
`define DHL_ACK_ERR 8'h45
`define DHL_TAG_PORT 8'h49
`define DHL_TAG_CHK 8'h43
`define DHL_ESC 8'h1B
`define DHL_LOCK 8'h4C
`define DHL_UNLOCK 8'h55
`define DHL_PKT_MAX 8'h20
`define DHL_QDEPTH 9'h100

// Timing
`define DHL_CLK_MHZ 250
`define DHL_BAUD_DEFAULT 19200
`define DHL_BAUD_DIV ((`DHL_CLK_MHZ * 1000000) / `DHL_BAUD_DEFAULT)
`define DHL_STORE_TIME_MS 9
`define DHL_STORE_CYCLES (`DHL_STORE_TIME_MS * 1000 * `DHL_CLK_MHZ)
`define DHL_INIT_TIME_US 1000
`define DHL_INIT_CYCLES (`DHL_INIT_TIME_US * `DHL_CLK_MHZ)

`endif

// File: rtl/dhl_pkg.sv
package dhl_pkg;

  // Packet framing states
  typedef enum logic [2:0] {PK_IDLE, PK_LEN, PK_DATA, PK_CHK, PK_FOOT, PK_DRAIN} dhl_pkt_st_t;

  // Serial engine state
  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_data;
    logic rx_par;
    logic rx_perr;
    logic rx_valid;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx_line;
  } dhl_uart_st_t;

  // Front end state
  typedef struct packed {
    logic wb_ack;
    logic [31:0] wb_dat;
    logic ser_sel, edge_rise, q_en, pkt_en;
    logic [1:0] parity;
    logic [15:0] baud;
    logic strb_s1, strb_s2, strb_prev;
    logic [7:0] dat_s1, dat_s2;
    logic hold_s1, hold_s2;
    logic [8:0] stored_s1, stored_s2;
    logic [1:0] start_cnt;
    logic init, storing, store_refused;
    logic [21:0] cyc_cnt;
    logic [8:0] bytes_left;
    logic in_valid;
    logic [7:0] in_byte;
    dhl_pkt_st_t pst;
    logic [7:0] pkt_len, pkt_idx, pkt_sum, pkt_chk;
    logic pkt_bad;
    logic [31:0][7:0] pkt_buf;
    logic [4:0] drain_idx;
    logic [255:0][7:0] q_mem;
    logic [7:0] q_wr, q_rd;
    logic [8:0] q_cnt;
    logic cmd_valid;
    logic [7:0] cmd_data;
    logic esc_seen, lock;
    logic ack_pend, tag_pend, dat_pend;
    logic [7:0] ack_byte, tag_byte, dat_byte;
    logic [7:0] good_cnt, bad_cnt;
    logic par_busy, ser_busy;
  } dhl_fe_st_t;

endpackage

// File: rtl/dhl_uart.sv
`timescale 1ns/1ns
`include "dhl_defs.svh"
module dhl_uart (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Line settings
  input wire logic [15:0] div_i,
  input wire logic [1:0] parity_i,
  // Serial pins
  input wire logic rx_i,
  output logic tx_o,
  // Received bytes
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  // Bytes to send
  input wire logic tx_start_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_busy_o
);
  import dhl_pkg::*;

  dhl_uart_st_t q, d; // Whole engine state
  logic par_en; // Parity bit present
  logic par_odd; // Odd parity selected

  // Next state of receiver and transmitter
  always_comb begin
    d = q;
    par_en = (parity_i == `DHL_PAR_EVEN) || (parity_i == `DHL_PAR_ODD);
    par_odd = (parity_i == `DHL_PAR_ODD);
    d.rx_s1 = rx_i;
    d.rx_s2 = q.rx_s1;
    d.rx_valid = 1'b0;
    // Receiver: start found on low, sampled mid-bit
    if (!q.rx_busy) begin
      if (!q.rx_s2) begin
        d.rx_busy = 1'b1;
        d.rx_cnt = {1'b0, div_i[15:1]};
        d.rx_bit = 4'h0;
        d.rx_par = 1'b0;
        d.rx_perr = 1'b0;
      end
    end else if (q.rx_cnt != 16'h0000) begin
      d.rx_cnt = q.rx_cnt - 16'h0001;
    end else begin
      d.rx_cnt = div_i - 16'h0001;
      d.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == 4'h0) begin
        // Glitch shorter than half a bit is dropped
        d.rx_busy = !q.rx_s2;
      end else if (q.rx_bit <= 4'h8) begin
        d.rx_data[3'(q.rx_bit - 4'h1)] = q.rx_s2;
        d.rx_par = q.rx_par ^ q.rx_s2;
      end else if (q.rx_bit == 4'h9 && par_en) begin
        d.rx_perr = (q.rx_par ^ q.rx_s2) != par_odd;
      end else begin
        // Stop bit: bad framing or parity loses the byte
        d.rx_busy = 1'b0;
        d.rx_valid = q.rx_s2 && !q.rx_perr;
      end
    end
    // Transmitter: start bit goes out at once
    if (!q.tx_busy) begin
      if (tx_start_i) begin
        d.tx_busy = 1'b1;
        d.tx_line = 1'b0;
        d.tx_cnt = div_i - 16'h0001;
        d.tx_sh = {1'b1, par_en ? (^tx_data_i) ^ par_odd : 1'b1, tx_data_i};
        d.tx_bit = par_en ? 4'hA : 4'h9;
      end
    end else if (q.tx_cnt != 16'h0000) begin
      d.tx_cnt = q.tx_cnt - 16'h0001;
    end else if (q.tx_bit == 4'h0) begin
      d.tx_busy = 1'b0;
    end else begin
      d.tx_line = q.tx_sh[0];
      d.tx_sh = {1'b1, q.tx_sh[9:1]};
      d.tx_bit = q.tx_bit - 4'h1;
      d.tx_cnt = div_i - 16'h0001;
    end
  end

  // State register; lines idle high
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
      q.tx_line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign tx_o = q.tx_line;
  assign rx_data_o = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  assign tx_busy_o = q.tx_busy;
endmodule

// File: rtl/dhl_front_end.sv
// Notes on behaviour
// - Parallel strobe edge captures whole data byte
// - Busy rises on receipt, falls when ready
// - Strobe active edge is a stored option
// - Serial defaults 19200 baud, no parity
// - Host hold stops transmission until released
// - Reset restores every default and settings
// - Initialisation adds 9ms per stored byte
// - 256-byte receive queue, option enabled
// - Tag 49H before status, 43H checksum
// - Frame: 02H, length, data, check, 03H
// - Check value is 8-bit data sum
// - Reply 50H on success, 45H on error
// - Failed packet data is dropped entirely
// - Packet mode forces queue; good data queued
// - 1BH 4CH locks, 1BH 55H unlocks store
// - Busy 9ms per stored macro byte
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`include "dhl_defs.svh"
module dhl_front_end #(
  parameter int unsigned BAUD_DIV = `DHL_BAUD_DIV,
  parameter int unsigned STORE_CYCLES = `DHL_STORE_CYCLES,
  parameter int unsigned INIT_CYCLES = `DHL_INIT_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Parallel port
  input wire logic PAR_STROBE_I,
  input wire logic [7:0] SHARED_DATA_LINES_I,
  output logic [7:0] SHARED_DATA_LINES_O,
  output logic [7:0] SHARED_DATA_LINES_OE_O,
  output logic PARALLEL_BUSY_OUT_O,
  // Serial port
  input wire logic SERIAL_RX_I,
  output logic SERIAL_TX_O,
  output logic SERIAL_MODULE_BUSY_OUT_O,
  input wire logic HOST_HOLD_IN_I,
  // Stored macro size
  input wire logic [8:0] STORED_BYTES_I,
  // Command processor
  output logic [7:0] CMD_DATA_O,
  output logic CMD_VALID_O,
  input wire logic CMD_ACCEPT_I
);
  import dhl_pkg::*;

  // Byte-lane merge for register writes
  function automatic logic [31:0] dhl_wmask(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Word decode of a byte offset
  function automatic logic dhl_hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  dhl_fe_st_t q, d; // Whole block state
  logic wb_req; // New bus request this cycle
  logic [31:0] ctrl_word; // Control register image
  logic [31:0] wr_val; // Merged write value
  logic [8:0] q_cap; // Live queue capacity
  logic space; // Queue can take a byte
  logic capture_ev; // Byte enters the input stage
  logic [7:0] cap_byte; // Byte being captured
  logic take; // Input stage consumed
  logic push, pop; // Queue write and read
  logic [7:0] push_byte; // Byte written to queue
  logic foot_take; // Footer byte judged
  logic pkt_ok; // Frame passed all checks
  logic tx_start; // Launch one serial byte
  logic [7:0] tx_byte; // Byte launched
  logic [7:0] rx_data; // Serial byte received
  logic rx_valid; // Serial byte strobe
  logic tx_busy; // Serial transmitter busy

  // Serial engine
  dhl_uart u_uart (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .div_i(q.baud),
    .parity_i(q.parity),
    .rx_i(SERIAL_RX_I),
    .tx_o(SERIAL_TX_O),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid),
    .tx_start_i(tx_start),
    .tx_data_i(tx_byte),
    .tx_busy_o(tx_busy)
  );

  // Next state of the whole front end
  always_comb begin
    d = q;
    capture_ev = 1'b0;
    cap_byte = 8'h00;
    take = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_byte = 8'h00;
    foot_take = 1'b0;
    pkt_ok = 1'b0;
    tx_start = 1'b0;
    tx_byte = 8'h00;
    // Pin synchronisers
    d.strb_s1 = PAR_STROBE_I;
    d.strb_s2 = q.strb_s1;
    d.strb_prev = q.strb_s2;
    d.dat_s1 = SHARED_DATA_LINES_I;
    d.dat_s2 = q.dat_s1;
    d.hold_s1 = HOST_HOLD_IN_I;
    d.hold_s2 = q.hold_s1;
    d.stored_s1 = STORED_BYTES_I;
    d.stored_s2 = q.stored_s1;
    ctrl_word = {26'h0, q.parity, q.pkt_en, q.q_en, q.edge_rise, q.ser_sel};
    wr_val = 32'h0;
    q_cap = (q.q_en || q.pkt_en) ? `DHL_QDEPTH : 9'h001;
    space = q.q_cnt < q_cap;

    // Startup: catch stored size, then wait out the check
    if (q.start_cnt != 2'h3) begin
      d.start_cnt = q.start_cnt + 2'h1;
      if (q.start_cnt == 2'h2) begin
        d.cyc_cnt = 22'(INIT_CYCLES - 1);
        d.bytes_left = q.stored_s2;
      end
    end else if (q.cyc_cnt != 22'h0) begin
      d.cyc_cnt = q.cyc_cnt - 22'h1;
    end else if (q.bytes_left != 9'h0) begin
      d.bytes_left = q.bytes_left - 9'h1;
      d.cyc_cnt = 22'(STORE_CYCLES - 1);
    end else begin
      d.init = 1'b0;
      d.storing = 1'b0;
    end

    // Byte source; a byte arriving while the stage is full is lost
    if (q.ser_sel) begin
      capture_ev = rx_valid && !q.in_valid;
      cap_byte = rx_data;
    end else begin
      // No edge until the synchroniser has filled, so a pin left high over reset is no strobe
      // selected strobe edge
      capture_ev = (q.edge_rise ? (q.strb_s2 && !q.strb_prev) : (!q.strb_s2 && q.strb_prev)) && !q.in_valid
                   && q.start_cnt == 2'h3;
      cap_byte = q.dat_s2;
    end

    // Transmit arbiter: reply first, then tag, then data
    // hold blocks new bytes
    if (!tx_busy && !q.hold_s2) begin
      if (q.ack_pend) begin
        tx_start = 1'b1;
        tx_byte = q.ack_byte;
        d.ack_pend = 1'b0;
      end else if (q.tag_pend) begin
        tx_start = 1'b1;
        tx_byte = q.tag_byte;
        d.tag_pend = 1'b0;
      end else if (q.dat_pend) begin
        tx_start = 1'b1;
        tx_byte = q.dat_byte;
        d.dat_pend = 1'b0;
      end
    end

    // Leaving packet mode abandons a half frame
    if (!q.pkt_en && q.pst != PK_DRAIN) begin
      d.pst = PK_IDLE;
    end

    // Input stage consumption
    if (q.in_valid && q.pst != PK_DRAIN) begin
      if (!q.pkt_en) begin
        if (space) begin
          push = 1'b1;
          push_byte = q.in_byte;
          take = 1'b1;
        end
      end else begin
        take = 1'b1;
        unique case (q.pst)
          PK_IDLE: begin
            // Stray bytes outside a frame are ignored
            if (q.in_byte == `DHL_HDR) begin
              d.pst = PK_LEN;
              d.pkt_sum = 8'h00;
              d.pkt_idx = 8'h00;
            end
          end
          PK_LEN: begin
            d.pkt_len = q.in_byte;
            d.pkt_bad = q.in_byte > `DHL_PKT_MAX;
            d.pst = (q.in_byte == 8'h00) ? PK_CHK : PK_DATA;
          end
          PK_DATA: begin
            // Overlong frames are counted through but not kept
            if (q.pkt_idx < `DHL_PKT_MAX) begin
              d.pkt_buf[q.pkt_idx[4:0]] = q.in_byte;
            end
            d.pkt_sum = q.pkt_sum + q.in_byte;
            d.pkt_idx = q.pkt_idx + 8'h01;
            if (q.pkt_idx + 8'h01 == q.pkt_len) begin
              d.pst = PK_CHK;
            end
          end
          PK_CHK: begin
            d.pkt_chk = q.in_byte;
            d.pst = PK_FOOT;
          end
          PK_FOOT: begin
            foot_take = 1'b1;
            pkt_ok = !q.pkt_bad && q.in_byte == `DHL_FTR && q.pkt_chk == q.pkt_sum;
            d.ack_pend = 1'b1;
            d.ack_byte = pkt_ok ? `DHL_ACK_OK : `DHL_ACK_ERR;
            d.drain_idx = 5'h00;
            if (pkt_ok && q.pkt_len != 8'h00) begin
              d.pst = PK_DRAIN;
            end else begin
              d.pst = PK_IDLE;
              d.good_cnt = pkt_ok ? q.good_cnt + 8'h01 : q.good_cnt;
              d.bad_cnt = pkt_ok ? q.bad_cnt : q.bad_cnt + 8'h01;
            end
          end
          PK_DRAIN: begin
          end
        endcase
      end
    end else if (q.pst == PK_DRAIN && space) begin
      push = 1'b1;
      push_byte = q.pkt_buf[q.drain_idx];
      d.drain_idx = q.drain_idx + 5'h01;
      if ({3'b000, q.drain_idx} + 8'h01 == q.pkt_len) begin
        d.pst = PK_IDLE;
        d.good_cnt = q.good_cnt + 8'h01;
      end
    end

    // Input stage fill; capture only happens when it is empty
    if (take) begin
      d.in_valid = 1'b0;
    end
    if (capture_ev) begin
      d.in_valid = 1'b1;
      d.in_byte = cap_byte;
    end

    // Queue write and lock watch
    if (push) begin
      d.q_mem[q.q_wr] = push_byte;
      d.q_wr = q.q_wr + 8'h01;
      if (q.esc_seen && push_byte == `DHL_LOCK) begin
        d.lock = 1'b1;
      end
      if (q.esc_seen && push_byte == `DHL_UNLOCK) begin
        d.lock = 1'b0;
      end
      d.esc_seen = push_byte == `DHL_ESC;
    end

    if ((!q.cmd_valid || CMD_ACCEPT_I) && q.q_cnt != 9'h000) begin
      pop = 1'b1;
      d.cmd_valid = 1'b1;
      d.cmd_data = q.q_mem[q.q_rd];
      d.q_rd = q.q_rd + 8'h01;
    end else if (CMD_ACCEPT_I) begin
      d.cmd_valid = 1'b0;
    end
    d.q_cnt = q.q_cnt + 9'(push) - 9'(pop);

    // Wishbone slave: answer one cycle after the request
    wb_req = WB_CYC_I && WB_STB_I && !q.wb_ack;
    d.wb_ack = wb_req;
    d.wb_dat = 32'h0;
    if (wb_req && !WB_WE_I) begin
      if (dhl_hit(WB_ADR_I, `DHL_REG_CTRL)) begin
        d.wb_dat = ctrl_word;
      end else if (dhl_hit(WB_ADR_I, `DHL_REG_BAUD)) begin
        d.wb_dat = {16'h0, q.baud};
      end else if (dhl_hit(WB_ADR_I, `DHL_REG_STATUS)) begin
        d.wb_dat = {15'h0, q.q_cnt, 2'b00, q.store_refused, tx_busy, q.storing, q.lock, q.init, q.par_busy};
      end else if (dhl_hit(WB_ADR_I, `DHL_REG_PKTSTAT)) begin
        d.wb_dat = {16'h0, q.bad_cnt, q.good_cnt};
      end
    end
    if (wb_req && WB_WE_I) begin
      if (dhl_hit(WB_ADR_I, `DHL_REG_CTRL)) begin
        wr_val = dhl_wmask(ctrl_word, WB_DAT_I, WB_SEL_I);
        d.ser_sel = wr_val[`DHL_CTRL_SER];
        d.edge_rise = wr_val[`DHL_CTRL_RISE];
        d.q_en = wr_val[`DHL_CTRL_QEN];
        d.pkt_en = wr_val[`DHL_CTRL_PKT];
        d.parity = wr_val[`DHL_CTRL_PAR_LO +: 2];
      end else if (dhl_hit(WB_ADR_I, `DHL_REG_BAUD)) begin
        wr_val = dhl_wmask({16'h0, q.baud}, WB_DAT_I, WB_SEL_I);
        d.baud = (wr_val[15:0] == 16'h0000) ? 16'h0001 : wr_val[15:0];
      end else if (dhl_hit(WB_ADR_I, `DHL_REG_TXREQ)) begin
        // A request while one is waiting is dropped
        if (!q.tag_pend && !q.dat_pend) begin
          d.dat_pend = 1'b1;
          d.dat_byte = WB_DAT_I[7:0];
          if ((q.q_en || q.pkt_en) && WB_DAT_I[9:8] != `DHL_KIND_RAW) begin
            d.tag_pend = 1'b1;
            d.tag_byte = (WB_DAT_I[9:8] == `DHL_KIND_PORT) ? `DHL_TAG_PORT : `DHL_TAG_CHK;
          end
        end
      end else if (dhl_hit(WB_ADR_I, `DHL_REG_STORE)) begin
        if (q.lock || q.init) begin
          d.store_refused = 1'b1;
        end else begin
          d.store_refused = 1'b0;
          d.bytes_left = WB_DAT_I[8:0];
          d.cyc_cnt = 22'h0;
          d.storing = WB_DAT_I[8:0] != 9'h000;
        end
      end
    end

    d.par_busy = d.in_valid || d.init || d.storing;
    d.ser_busy = d.in_valid || d.init || d.storing;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      q <= '0;
      q.edge_rise <= `DHL_CTRL_RISE_RST;
      q.ser_sel <= `DHL_CTRL_SER_RST;
      q.baud <= 16'(BAUD_DIV);
      q.parity <= `DHL_PAR_NONE;
      q.init <= 1'b1;
      q.par_busy <= 1'b1;
      q.ser_busy <= 1'b1;
      q.hold_s1 <= 1'b1;
      q.hold_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs; data lines are only ever read here
  assign WB_DAT_O = q.wb_dat;
  assign WB_ACK_O = q.wb_ack;
  assign SHARED_DATA_LINES_O = 8'h00;
  assign SHARED_DATA_LINES_OE_O = 8'h00;
  assign PARALLEL_BUSY_OUT_O = q.par_busy;
  assign SERIAL_MODULE_BUSY_OUT_O = q.ser_busy;
  assign CMD_DATA_O = q.cmd_data;
  assign CMD_VALID_O = q.cmd_valid;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);

  property p_capture;
    capture_ev && !q.ser_sel |=> q.in_valid && q.in_byte == $past(q.dat_s2);
  endproperty
  a_capture: assert property (p_capture) else $error("parallel byte not captured");

  property p_busy_rx;
    capture_ev |=> PARALLEL_BUSY_OUT_O && SERIAL_MODULE_BUSY_OUT_O;
  endproperty
  a_busy_rx: assert property (p_busy_rx) else $error("busy missing after byte");

  property p_wrong_edge;
    !q.ser_sel && q.edge_rise && !q.in_valid && q.strb_prev && !q.strb_s2 |=> !q.in_valid;
  endproperty
  a_wrong_edge: assert property (p_wrong_edge) else $error("capture on inactive edge");

  property p_hold;
    q.hold_s2 && !tx_busy |=> !tx_busy ##1 (!tx_busy || !$past(q.hold_s2));
  endproperty
  a_hold: assert property (p_hold) else $error("transmit while host holds");

  property p_init_busy;
    q.init |-> PARALLEL_BUSY_OUT_O && SERIAL_MODULE_BUSY_OUT_O;
  endproperty
  a_init_busy: assert property (p_init_busy) else $error("not busy during init");

  property p_store;
    q.storing && q.bytes_left != 9'h0 |=> q.storing && PARALLEL_BUSY_OUT_O;
  endproperty
  a_store: assert property (p_store) else $error("store busy ended early");

  property p_ack;
    foot_take |=> q.ack_pend && q.ack_byte == ($past(pkt_ok) ? `DHL_ACK_OK : `DHL_ACK_ERR);
  endproperty
  a_ack: assert property (p_ack) else $error("wrong packet reply");

  property p_drop;
    foot_take && !pkt_ok |=> q.pst == PK_IDLE && q.q_cnt <= $past(q.q_cnt);
  endproperty
  a_drop: assert property (p_drop) else $error("bad packet data kept");

  property p_tag;
    wb_req && WB_WE_I && dhl_hit(WB_ADR_I, `DHL_REG_TXREQ) && !q.tag_pend && !q.dat_pend && q.q_en
      && WB_DAT_I[9:8] == `DHL_KIND_PORT |=> q.tag_pend && q.tag_byte == `DHL_TAG_PORT;
  endproperty
  a_tag: assert property (p_tag) else $error("status tag missing");

  property p_order;
    q.cmd_valid && !CMD_ACCEPT_I |=> q.cmd_valid && $stable(q.cmd_data);
  endproperty
  a_order: assert property (p_order) else $error("command byte lost");
endmodule

// File: dv/dhl_host_model.sv
`timescale 1ns/1ns
module dhl_host_model #(
  parameter int DIV = 8
) (
  // Clock and device busy
  input wire logic clk_i,
  input wire logic busy_i,
  // Pins toward the device
  output logic strobe_o,
  output logic [7:0] data_o,
  output logic rx_o
);
  // Idle levels, serial line high
  initial begin
    strobe_o = 1'b0;
    data_o = 8'h00;
    rx_o = 1'b1;
  end
  task automatic par_send(input logic [7:0] b, input logic rise);
    while (busy_i !== 1'b0) @(posedge clk_i);
    strobe_o <= !rise;
    data_o <= b;
    repeat (3) @(posedge clk_i);
    strobe_o <= rise;
    while (busy_i !== 1'b1) @(posedge clk_i);
    // Lines no longer valid, so show garbage
    data_o <= ~b;
  endtask
  task automatic ser_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o <= f[i];
      repeat (DIV) @(posedge clk_i);
    end
  endtask
endmodule

// File: dv/dhl_front_end_tb.sv
`timescale 1ns/1ns
module dhl_front_end_tb;
  // Bench drive and sample signals
  logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0, hold = 1'b0, acc = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [8:0] stored = 9'h001;
  logic [31:0] wdat = 32'h0, r;
  wire logic [31:0] rdat;
  wire logic ack, busy, busy2, tx, cval, strb, rx;
  wire logic [7:0] cdat, pdat, pout, poe;
  int error_cnt = 0, total_checks = 0;
  logic [7:0] cq[$];
  always #2 clk = ~clk;
  // Short counts keep the run brief
  dhl_front_end #(.BAUD_DIV(8), .STORE_CYCLES(16), .INIT_CYCLES(20)) i_dhl_front_end (
    .CLOCK_I(clk), .RST_B_I(rst_b), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PAR_STROBE_I(strb), .SHARED_DATA_LINES_I(pdat), .SHARED_DATA_LINES_O(pout),
    .SHARED_DATA_LINES_OE_O(poe), .PARALLEL_BUSY_OUT_O(busy), .SERIAL_RX_I(rx), .SERIAL_TX_O(tx),
    .SERIAL_MODULE_BUSY_OUT_O(busy2), .HOST_HOLD_IN_I(hold), .STORED_BYTES_I(stored),
    .CMD_DATA_O(cdat), .CMD_VALID_O(cval), .CMD_ACCEPT_I(acc));
  dhl_host_model i_dhl_host_model (.clk_i(clk), .busy_i(busy), .strobe_o(strb),
    .data_o(pdat), .rx_o(rx));
  // Collect bytes taken by the command side
  always @(posedge clk) if (cval === 1'b1 && acc) cq.push_back(cdat);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // Classic single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 100);
    chk("bus ack", 1, ack);
    r = rdat;
    req <= 1'b0;
    @(posedge clk);
  endtask
  // Sample mid bit at eight clocks per bit
  task automatic rx_get(input logic [7:0] e);
    logic [7:0] b;
    int n = 0;
    while (tx !== 1'b0 && n++ < 4000) @(posedge clk);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (8) @(posedge clk);
      b[i] = tx;
    end
    repeat (8) @(posedge clk);
    chk("tx byte", e, b);
  endtask
  task automatic take(input logic [7:0] e);
    int n = 0;
    while (cq.size() == 0 && n++ < 300) @(posedge clk);
    chk("cmd byte", e, cq.size() ? cq.pop_front() : 8'hXX);
  endtask
  // Two data bytes, given check, expected reply
  task automatic frame(input logic [7:0] c, input logic [7:0] f);
    logic [47:0] s;
    s = {8'h02, 8'h02, 8'hA1, 8'hB2, c, 8'h03};
    for (int i = 5; i >= 0; i--) i_dhl_host_model.ser_send(s[i*8+:8]);
    rx_get(f);
  endtask
  task automatic t_reset();
    int n = 0;
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    chk("busy in reset", 1, busy);
    rst_b <= 1'b1;
    while (busy !== 1'b0 && n++ < 500) @(posedge clk);
    chk("init span", 1, n >= 20 + 16 * stored && n <= 26 + 16 * stored);
    wb(0, 8'h00, 0);
    chk("ctrl", 32'h2, r);
    wb(0, 8'h04, 0);
    chk("baud", 32'h8, r);
    wb(0, 8'h1C, 0);
    chk("unmapped", 0, r);
    sel <= 4'h2;
    wb(1, 8'h04, 32'h33FF);
    sel <= 4'hF;
    wb(0, 8'h04, 0);
    chk("byte lanes", 32'h3308, r);
    wb(1, 8'h04, 32'h8);
    chk("no stray byte", 0, cq.size());
    chk("lines released", 0, {pout, poe});
    $display("test reset done");
  endtask
  task automatic t_par();
    i_dhl_host_model.par_send(8'hA5, 1'b1);
    take(8'hA5);
    chk("busy free", 0, busy);
    i_dhl_host_model.par_send(8'h3C, 1'b1);
    take(8'h3C);
    wb(1, 8'h00, 32'h0);
    i_dhl_host_model.par_send(8'h5A, 1'b0);
    take(8'h5A);
    $display("test parallel done");
  endtask
  task automatic t_pkt();
    wb(1, 8'h00, 32'h9);
    frame(8'h53, 8'h50);
    take(8'hA1);
    take(8'hB2);
    frame(8'h54, 8'h45);
    repeat (20) @(posedge clk);
    chk("dropped", 0, cq.size());
    frame(8'h53, 8'h50);
    take(8'hA1);
    take(8'hB2);
    wb(0, 8'h14, 0);
    chk("pkt counts", 32'h0102, r);
    $display("test packet done");
  endtask
  task automatic t_hold();
    int n = 0;
    wb(1, 8'h00, 32'h5);
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1, 8'h0C, 32'h17E);
    repeat (100) begin
      @(posedge clk);
      n += (tx !== 1'b1);
    end
    chk("held", 0, n);
    hold <= 1'b0;
    rx_get(8'h49);
    rx_get(8'h7E);
    wb(1, 8'h0C, 32'h255);
    rx_get(8'h43);
    rx_get(8'h55);
    wb(1, 8'h00, 32'h15);
    wb(1, 8'h0C, 32'h003);
    rx_get(8'h03);
    chk("even parity bit", 0, tx);
    wb(1, 8'h00, 32'h5);
    $display("test hold done");
  endtask
  task automatic t_lock();
    int n = 0;
    acc <= 1'b0;
    i_dhl_host_model.ser_send(8'h1B);
    i_dhl_host_model.ser_send(8'h4C);
    repeat (4) @(posedge clk);
    chk("cmd held", 32'h11B, {cval, cdat});
    wb(0, 8'h08, 0);
    chk("status", 32'h104, r);
    acc <= 1'b1;
    take(8'h1B);
    take(8'h4C);
    wb(1, 8'h10, 32'h1);
    wb(0, 8'h08, 0);
    chk("locked", 32'h24, r & 32'h24);
    i_dhl_host_model.ser_send(8'h1B);
    i_dhl_host_model.ser_send(8'h55);
    take(8'h1B);
    take(8'h55);
    wb(1, 8'h10, 32'h2);
    repeat (24) @(posedge clk);
    chk("store busy", 1, busy2);
    while (busy !== 1'b0 && n++ < 20) @(posedge clk);
    chk("store end", 0, busy);
    $display("test lock done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Second reset proves defaults come back
  initial begin
    t_reset();
    t_par();
    t_pkt();
    t_hold();
    t_lock();
    stored <= 9'h002;
    t_reset();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
